// ---- rtl/fcs_pkg.sv ----
// package: register map, fields and command codes of the flash command block
package fcs_pkg;
    // ********************************************************
    // register indices (byte address = 4 * index)
    // ********************************************************
    localparam logic [3:0] IDX_PARAM_INDEX = 4'h2;
    localparam logic [3:0] IDX_CONFIG      = 4'h4;
    localparam logic [3:0] IDX_STATUS      = 4'h6;
    localparam logic [3:0] IDX_FAULT       = 4'h7;
    localparam logic [3:0] IDX_PARAM       = 4'h8;
    localparam int         ADDR_W          = 6;
    // ********************************************************
    // fields
    // ********************************************************
    localparam int BIT_DONE      = 7;
    localparam int BIT_ACC_ERR   = 5;
    localparam int BIT_PROT_VIOL = 4;
    localparam int BIT_BUSY      = 3;
    localparam int BIT_MG_HI     = 1;
    localparam int BIT_MG_LO     = 0;
    localparam int BIT_DFAULT    = 1;
    localparam int BIT_SFAULT    = 0;
    localparam int BIT_IGN_SF    = 0;
    // ********************************************************
    // commands and parameter slots
    // ********************************************************
    localparam logic [7:0]  CMD_READ_ONCE = 8'h04;
    localparam logic [7:0]  CMD_PROGRAM   = 8'h06;
    localparam logic [2:0]  IX_ADDR_LO    = 3'h1;
    localparam logic [2:0]  IX_DATA0      = 3'h2;
    localparam int          NUM_PARAM     = 6;
    localparam logic [15:0] RO_MAX_INDEX  = 16'h0007;
    localparam logic [1:0]  LAST_WORD     = 2'h3;
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_WRITE = 2'b01,
        ST_READ  = 2'b10
    } fcs_state_e;
endpackage

// ---- rtl/fcs_flash_cmd.sv ----
// flash command sequencer and fault status block with an avalon-mm slave
// How it works
// RULE_01: array read with double fault or busy-block collision sets double-fault flag.
// RULE_02: writing one clears the double-fault flag; zero leaves it.
// RULE_03: single fault or collision sets single-fault flag unless ignore bit set.
// RULE_04: writing one clears the single-fault flag; zero has no effect.
// RULE_05: ECC sets one flag only; both high means read during command.
// RULE_06: fault flags land in status one cycle after the read.
// RULE_07: fault flags stay readable, only clearing writes act; register at 0x7.
// RULE_08: read once fetches the phrase into parameters, then sets complete flag.
// RULE_09: read once phrase index 0 to 7 only, others give access error.
// RULE_10: pflash reads during read once return invalid data.
// RULE_11: read once access error if index bits not 001; never protection fault.
// RULE_12: read once sets error high on any fault, low on uncorrectable.
// RULE_13: software loads code, address and four data words by index.
// RULE_14: software supplies a phrase aligned program address.
// RULE_15: program writes four words, reads them back to verify, then completes.
// RULE_16: software only programs erased phrases, never cumulatively.
// RULE_17: while complete flag is zero, no launch and parameter writes ignored.
// RULE_18: parameter index bits select which parameter word is accessed.
// RULE_19: writing one clears complete flag and launches; it returns when done.
// RULE_20: controller error bits set on errors during command execution.
// RULE_21: busy flag reads one while a command runs, zero when idle.
`timescale 1ns/1ps
`default_nettype none
module fcs_flash_cmd (
    // clock and reset
    input  wire logic        i_core_clk,
    input  wire logic        i_rst_n,
    // avalon-mm slave
    input  wire logic [5:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    input  wire logic [3:0]  i_avs_byteenable,
    output logic      [31:0] o_avs_readdata,
    output logic             o_avs_waitrequest,
    // cpu array read port
    input  wire logic        i_cpu_rd,
    input  wire logic        i_cpu_rd_pflash,
    input  wire logic        i_cpu_ecc_single,
    input  wire logic        i_cpu_ecc_double,
    output logic             o_cpu_rd_invalid,
    // flash array port used by commands
    input  wire logic        i_read_once_allowed,
    input  wire logic        i_arr_ack,
    input  wire logic [15:0] i_arr_rdata,
    input  wire logic        i_arr_ecc_single,
    input  wire logic        i_arr_ecc_double,
    output logic             o_arr_req,
    output logic             o_arr_we,
    output logic             o_arr_ifr,
    output logic      [17:0] o_arr_addr,
    output logic      [15:0] o_arr_wdata
);
    // ********************************************************
    // state
    // ********************************************************
    typedef struct packed {
        // bus answer
        logic                   ack;
        logic [31:0]            rdata;
        // status and configuration
        logic                   done;
        logic                   acc_err;
        logic                   prot_viol;
        logic [1:0]             ctl_err;
        logic                   ign_sf;
        // fault flags and their pending stage
        logic                   sf_flag;
        logic                   df_flag;
        logic                   pend_sf;
        logic                   pend_df;
        // parameters and command sequencing
        logic [2:0]             ix;
        logic [5:0][15:0]       prm;
        fcs_pkg::fcs_state_e    st;
        logic [1:0]             wcnt;
        logic                   ro;
        logic [17:0]            base;
    } fcs_state_s;

    fcs_state_s r;
    fcs_state_s next_r;

    logic        req;
    logic        bus_wr;
    logic [3:0]  idx;
    logic        launch;
    logic        busy;
    logic [2:0]  slot;

    // ********************************************************
    // bus decode
    // ********************************************************
    assign req    = i_avs_read | i_avs_write;
    assign idx    = i_avs_address[5:2];
    // a write acts on its answer edge only, so a held request writes every second cycle
    assign bus_wr = i_avs_write & r.ack;
    assign busy   = ~r.done;
    assign slot   = fcs_pkg::IX_DATA0 + {1'b0, r.wcnt};

    // one wait cycle per access, answer on the second
    assign o_avs_waitrequest = req & ~r.ack;
    assign o_avs_readdata    = r.rdata;

    // ********************************************************
    // array ports
    // ********************************************************
    // combinational so a cpu read is marked invalid in its own cycle
    assign o_cpu_rd_invalid = busy & i_cpu_rd_pflash; // RULE_10
    assign o_arr_req   = r.st != fcs_pkg::ST_IDLE;
    assign o_arr_we    = r.st == fcs_pkg::ST_WRITE;
    assign o_arr_ifr   = r.ro;
    assign o_arr_addr  = r.base + {15'h0, r.wcnt, 1'b0};
    assign o_arr_wdata = r.prm[slot];

    // the command is judged on the parameter words held before this edge
    assign launch = bus_wr && idx == fcs_pkg::IDX_STATUS && i_avs_byteenable[0]
                    && i_avs_writedata[fcs_pkg::BIT_DONE] && r.done;

    // ********************************************************
    // next state
    // ********************************************************
    always_comb begin
        logic set_sf;
        logic set_df;
        logic coll;
        logic last;
        set_sf = 1'b0;
        set_df = 1'b0;
        coll   = 1'b0;
        last   = 1'b0;
        next_r = r;
        next_r.ack = req & ~r.ack;

        // ****************************************************
        // register reads, prepared in the wait cycle
        // ****************************************************
        if (req && !r.ack) begin
            next_r.rdata = 32'h0;
            if (idx == fcs_pkg::IDX_PARAM_INDEX) begin
                next_r.rdata[2:0] = r.ix;
            end else if (idx == fcs_pkg::IDX_CONFIG) begin
                next_r.rdata[fcs_pkg::BIT_IGN_SF] = r.ign_sf;
            end else if (idx == fcs_pkg::IDX_STATUS) begin
                next_r.rdata[fcs_pkg::BIT_DONE]      = r.done;
                next_r.rdata[fcs_pkg::BIT_ACC_ERR]   = r.acc_err;
                next_r.rdata[fcs_pkg::BIT_PROT_VIOL] = r.prot_viol;
                next_r.rdata[fcs_pkg::BIT_BUSY]      = busy; // RULE_21
                next_r.rdata[1:0]                    = r.ctl_err;
            end else if (idx == fcs_pkg::IDX_FAULT) begin
                next_r.rdata[fcs_pkg::BIT_DFAULT] = r.df_flag; // RULE_07
                next_r.rdata[fcs_pkg::BIT_SFAULT] = r.sf_flag;
            end else if (idx == fcs_pkg::IDX_PARAM) begin
                // index 6 and 7 hold no word and read as zero
                if (r.ix < fcs_pkg::NUM_PARAM[2:0]) begin
                    next_r.rdata[15:0] = r.prm[r.ix]; // RULE_18
                end
            end
        end

        // ****************************************************
        // register writes
        // ****************************************************
        if (bus_wr) begin
            if (idx == fcs_pkg::IDX_PARAM_INDEX && i_avs_byteenable[0]) begin
                next_r.ix = i_avs_writedata[2:0];
            end else if (idx == fcs_pkg::IDX_CONFIG && i_avs_byteenable[0]) begin
                next_r.ign_sf = i_avs_writedata[fcs_pkg::BIT_IGN_SF];
            end else if (idx == fcs_pkg::IDX_STATUS && i_avs_byteenable[0]) begin
                if (i_avs_writedata[fcs_pkg::BIT_ACC_ERR]) begin
                    next_r.acc_err = 1'b0;
                end
                if (i_avs_writedata[fcs_pkg::BIT_PROT_VIOL]) begin
                    next_r.prot_viol = 1'b0;
                end
            end else if (idx == fcs_pkg::IDX_FAULT && i_avs_byteenable[0]) begin
                // a zero bit leaves its flag alone
                if (i_avs_writedata[fcs_pkg::BIT_DFAULT]) begin
                    next_r.df_flag = 1'b0; // RULE_02
                end
                if (i_avs_writedata[fcs_pkg::BIT_SFAULT]) begin
                    next_r.sf_flag = 1'b0; // RULE_04
                end
            end else if (idx == fcs_pkg::IDX_PARAM && r.done
                         && r.ix < fcs_pkg::NUM_PARAM[2:0]) begin // RULE_17
                // bus writes to parameter words are ignored while a command runs
                if (i_avs_byteenable[0]) begin
                    next_r.prm[r.ix][7:0] = i_avs_writedata[7:0]; // RULE_18
                end
                if (i_avs_byteenable[1]) begin
                    next_r.prm[r.ix][15:8] = i_avs_writedata[15:8];
                end
            end
        end

        // ****************************************************
        // launch
        // ****************************************************
        if (launch) begin
            next_r.done    = 1'b0; // RULE_19
            // controller errors of the previous command are dropped here
            next_r.ctl_err = 2'b00;
            next_r.wcnt    = 2'b00;
            next_r.ro      = 1'b0;
            if (r.prm[0][15:8] == fcs_pkg::CMD_READ_ONCE) begin
                // protection violation is never raised here
                if (r.ix != fcs_pkg::IX_ADDR_LO || !i_read_once_allowed
                    || r.prm[1] > fcs_pkg::RO_MAX_INDEX) begin // RULE_09 RULE_11
                    // a refused command keeps the complete flag set, so no array access starts
                    next_r.acc_err = 1'b1;
                    next_r.done    = 1'b1;
                end else begin
                    next_r.ro   = 1'b1; // RULE_08
                    next_r.st   = fcs_pkg::ST_READ;
                    next_r.base = {12'h0, r.prm[1][2:0], 3'h0};
                end
            end else if (r.prm[0][15:8] == fcs_pkg::CMD_PROGRAM) begin
                // the low address bits are taken as supplied
                next_r.st   = fcs_pkg::ST_WRITE; // RULE_15
                next_r.base = {r.prm[0][1:0], r.prm[1]};
            end else begin
                next_r.acc_err = 1'b1;
                next_r.done    = 1'b1;
            end
        end

        // ****************************************************
        // command sequencing, one array word per ack
        // ****************************************************
        last = r.wcnt == fcs_pkg::LAST_WORD;
        case (r.st)
            fcs_pkg::ST_WRITE: begin
                if (i_arr_ack) begin
                    next_r.wcnt = r.wcnt + 2'h1;
                    if (last) begin
                        // the word counter wraps to zero, so verify starts at word 0
                        next_r.st = fcs_pkg::ST_READ; // RULE_15
                    end
                end
            end
            fcs_pkg::ST_READ: begin
                if (i_arr_ack) begin
                    next_r.wcnt = r.wcnt + 2'h1;
                    if (r.ro) begin
                        next_r.prm[slot] = i_arr_rdata; // RULE_08
                    end else if (i_arr_rdata != r.prm[slot]) begin
                        // verify compares against the words just written
                        next_r.ctl_err[fcs_pkg::BIT_MG_HI] = 1'b1; // RULE_20
                    end
                    if (i_arr_ecc_single || i_arr_ecc_double) begin
                        next_r.ctl_err[fcs_pkg::BIT_MG_HI] = 1'b1; // RULE_12
                    end
                    if (i_arr_ecc_double) begin
                        next_r.ctl_err[fcs_pkg::BIT_MG_LO] = 1'b1; // RULE_12
                    end
                    if (last) begin
                        next_r.st   = fcs_pkg::ST_IDLE;
                        next_r.ro   = 1'b0;
                        next_r.done = 1'b1; // RULE_19
                    end
                end
            end
            default: begin
                // idle: a launch above has already set up the next command
            end
        endcase

        // ****************************************************
        // fault flags, stored one cycle after the read
        // ****************************************************
        coll = i_cpu_rd & i_cpu_rd_pflash & busy;
        next_r.pend_df = i_cpu_rd & (coll | i_cpu_ecc_double); // RULE_06
        // a double fault masks the single one so ecc never sets both
        next_r.pend_sf = i_cpu_rd & ~r.ign_sf
                         & (coll | (i_cpu_ecc_single & ~i_cpu_ecc_double)); // RULE_05
        // pending stage: flags appear one cycle after the read that raised them
        set_df = r.pend_df;
        set_sf = r.pend_sf;
        // a new fault wins over a clearing write in the same cycle
        if (set_df) begin
            next_r.df_flag = 1'b1; // RULE_01
        end
        if (set_sf) begin
            next_r.sf_flag = 1'b1; // RULE_03
        end
    end

    // ********************************************************
    // state register
    // ********************************************************
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            r      <= '0;
            r.done <= 1'b1;
            r.st   <= fcs_pkg::ST_IDLE;
        end else begin
            r <= next_r;
        end
    end
endmodule
`default_nettype wire

// ---- verif/fcs_flash_cmd_checker.sv ----
// assertion checker bound to the flash command and fault status block
`timescale 1ns/1ps
`default_nettype none
module fcs_flash_cmd_checker (
    // clock, reset and register bus
    input wire logic        i_core_clk,
    input wire logic        i_rst_n,
    input wire logic [5:0]  i_avs_address,
    input wire logic        i_avs_read,
    input wire logic        i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0]  i_avs_byteenable,
    input wire logic [31:0] o_avs_readdata,
    input wire logic        o_avs_waitrequest,
    // cpu read and array ports
    input wire logic        i_cpu_rd,
    input wire logic        i_cpu_rd_pflash,
    input wire logic        i_cpu_ecc_single,
    input wire logic        i_cpu_ecc_double,
    input wire logic        o_cpu_rd_invalid,
    input wire logic        i_read_once_allowed,
    input wire logic        i_arr_ack,
    input wire logic [15:0] i_arr_rdata,
    input wire logic        i_arr_ecc_single,
    input wire logic        i_arr_ecc_double,
    input wire logic        o_arr_req,
    input wire logic        o_arr_we,
    input wire logic        o_arr_ifr,
    input wire logic [17:0] o_arr_addr,
    input wire logic [15:0] o_arr_wdata
);
    // ********************************************************
    // assertions
    // ********************************************************
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);
    one_wait_a: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
        else $error("bus answer not after one wait cycle");
    invalid_data_a: assert property (o_cpu_rd_invalid == (o_arr_req && i_cpu_rd_pflash))
        else $error("pflash read validity wrong");
    idle_quiet_a: assert property (!o_arr_req |-> !o_arr_we && !o_arr_ifr)
        else $error("array strobes active while idle");
    once_reads_a: assert property (o_arr_ifr |-> !o_arr_we && o_arr_addr[17:6] == 12'h000)
        else $error("read once access out of phrase range");
    hold_access_a: assert property (o_arr_req && !i_arr_ack |=> o_arr_req && $stable(o_arr_addr) && $stable(o_arr_we))
        else $error("array access changed before ack");
    verify_phase_a: assert property (o_arr_req && o_arr_we && i_arr_ack && o_arr_addr[2:0] == 3'h6
        |=> o_arr_req && !o_arr_we && o_arr_addr[2:0] == 3'h0) else $error("no verify after last write");
    finish_cmd_a: assert property (o_arr_req && !o_arr_we && i_arr_ack && o_arr_addr[2:0] == 3'h6 |=> !o_arr_req)
        else $error("command did not end after last read");
    launch_cause_a: assert property ($rose(o_arr_req) |-> $past(i_avs_write && !o_avs_waitrequest
        && i_avs_address[5:2] == fcs_pkg::IDX_STATUS && i_avs_writedata[7])) else $error("command started without launch");
endmodule
bind fcs_flash_cmd fcs_flash_cmd_checker chk (
    .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
    .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
    .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest), .i_cpu_rd(i_cpu_rd),
    .i_cpu_rd_pflash(i_cpu_rd_pflash), .i_cpu_ecc_single(i_cpu_ecc_single), .i_cpu_ecc_double(i_cpu_ecc_double),
    .o_cpu_rd_invalid(o_cpu_rd_invalid), .i_read_once_allowed(i_read_once_allowed), .i_arr_ack(i_arr_ack),
    .i_arr_rdata(i_arr_rdata), .i_arr_ecc_single(i_arr_ecc_single), .i_arr_ecc_double(i_arr_ecc_double),
    .o_arr_req(o_arr_req), .o_arr_we(o_arr_we), .o_arr_ifr(o_arr_ifr), .o_arr_addr(o_arr_addr),
    .o_arr_wdata(o_arr_wdata)
);
`default_nettype wire

// ---- verif/tb.sv ----
// self-checking bench for the flash command and fault status block
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        i_core_clk = 0, i_rst_n = 0, i_avs_read = 0, i_avs_write = 0, i_cpu_rd = 0, i_cpu_rd_pflash = 0;
    logic        i_cpu_ecc_single = 0, i_cpu_ecc_double = 0, i_read_once_allowed = 1, i_arr_ack = 0;
    logic        i_arr_ecc_single = 0, i_arr_ecc_double = 0, o_avs_waitrequest, o_cpu_rd_invalid;
    logic        o_arr_req, o_arr_we, o_arr_ifr, hold = 0;
    logic [5:0]  i_avs_address = 0;
    logic [3:0]  i_avs_byteenable = 4'hf;
    logic [31:0] i_avs_writedata = 0, o_avs_readdata, q;
    logic [15:0] i_arr_rdata = 0, o_arr_wdata, d [4];
    logic [17:0] o_arr_addr, a;
    logic [15:0] mem [int];
    int          mismatches = 0, checks = 0, seed = 32'h100fd32f, dfl = 0, sfl = 0, ign = 0, busy = 0, k, w;
    fcs_flash_cmd uut (
        .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
        .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
        .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest), .i_cpu_rd(i_cpu_rd),
        .i_cpu_rd_pflash(i_cpu_rd_pflash), .i_cpu_ecc_single(i_cpu_ecc_single), .i_cpu_ecc_double(i_cpu_ecc_double),
        .o_cpu_rd_invalid(o_cpu_rd_invalid), .i_read_once_allowed(i_read_once_allowed), .i_arr_ack(i_arr_ack),
        .i_arr_rdata(i_arr_rdata), .i_arr_ecc_single(i_arr_ecc_single), .i_arr_ecc_double(i_arr_ecc_double),
        .o_arr_req(o_arr_req), .o_arr_we(o_arr_we), .o_arr_ifr(o_arr_ifr), .o_arr_addr(o_arr_addr),
        .o_arr_wdata(o_arr_wdata)
    );
    // ********************************************************
    // clock, array responder and bus tasks
    // ********************************************************
    always #25 i_core_clk = ~i_core_clk;
    // unwritten cells read back an address pattern so stale data cannot match
    function automatic logic [15:0] rd(input logic f, input int ad);
        return mem.exists({f, ad[17:0]}) ? mem[{f, ad[17:0]}] : ~ad[15:0] ^ {15'h0, f};
    endfunction
    // hold keeps a command running so its busy window can be probed
    always @(posedge i_core_clk) begin
        if (i_arr_ack && o_arr_we) mem[{o_arr_ifr, o_arr_addr}] = o_arr_wdata;
        i_arr_ack <= o_arr_req && !i_arr_ack && !hold && ($random(seed) % 3 == 0);
        i_arr_rdata <= rd(o_arr_ifr, o_arr_addr);
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic bus(input logic wr, input logic [3:0] ix, input logic [31:0] v);
        @(posedge i_core_clk);
        i_avs_address <= {ix, 2'b00};
        i_avs_write <= wr;
        i_avs_read <= !wr;
        i_avs_writedata <= v;
        do @(posedge i_core_clk); while (o_avs_waitrequest);
        q = o_avs_readdata;
        i_avs_write <= 1'b0;
        i_avs_read <= 1'b0;
    endtask
    task automatic rdc(input logic [3:0] ix, input logic [31:0] e);
        bus(1'b0, ix, 32'h0);
        chk(q, e);
    endtask
    task automatic setp(input logic [2:0] ix, input logic [15:0] v);
        bus(1'b1, fcs_pkg::IDX_PARAM_INDEX, {29'h0, ix});
        bus(1'b1, fcs_pkg::IDX_PARAM, {16'h0, v});
    endtask
    task automatic cpu(input int pf, input int s, input int db);
        @(posedge i_core_clk);
        {i_cpu_rd, i_cpu_rd_pflash, i_cpu_ecc_single, i_cpu_ecc_double} <= {1'b1, pf[0], s[0], db[0]};
        #1 chk(o_cpu_rd_invalid, pf & busy);
        dfl |= db | (pf & busy);
        if (ign == 0) sfl |= s | (pf & busy);
        @(posedge i_core_clk);
        {i_cpu_rd, i_cpu_rd_pflash, i_cpu_ecc_single, i_cpu_ecc_double} <= 4'h0;
        repeat (2) @(posedge i_core_clk);
    endtask
    task automatic cmd(input logic [15:0] p0, input logic [15:0] p1, input int ix);
        setp(3'h0, p0);
        setp(3'h1, p1);
        bus(1'b1, fcs_pkg::IDX_PARAM_INDEX, ix);
        hold = 1;
        bus(1'b1, fcs_pkg::IDX_STATUS, 32'h80);
    endtask
    task automatic finish_cmd;
        hold = 0;
        while (o_arr_req) @(posedge i_core_clk);
        busy = 0;
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        #2000000;
        mismatches++;
        complete_run();
    end
    initial begin
        repeat (4) @(posedge i_core_clk);
        i_rst_n <= 1'b1;
        rdc(fcs_pkg::IDX_STATUS, 32'h80);
        rdc(fcs_pkg::IDX_FAULT, 32'h0);
        rdc(4'h3, 32'h0);
        for (k = 0; k < 24; k++) begin
            ign = k > 15;
            bus(1'b1, fcs_pkg::IDX_CONFIG, ign);
            w = $random(seed);
            cpu(0, w[0] & ~w[1], w[1]);
            rdc(fcs_pkg::IDX_FAULT, 2 * dfl + sfl);
            bus(1'b1, fcs_pkg::IDX_FAULT, {30'h0, w[3:2]});
            dfl &= ~w[3];
            sfl &= ~w[2];
            rdc(fcs_pkg::IDX_FAULT, 2 * dfl + sfl);
        end
        a = $random(seed);
        a[2:0] = 3'h0;
        for (w = 0; w < 4; w++) d[w] = $random(seed);
        for (w = 0; w < 4; w++) setp(3'(w + 2), d[w]);
        cmd({14'h0180, a[17:16]}, a[15:0], 5);
        busy = 1;
        cpu(1, 0, 0);
        bus(1'b1, fcs_pkg::IDX_PARAM, 32'hbeef);
        rdc(fcs_pkg::IDX_STATUS, 32'h08);
        finish_cmd();
        rdc(fcs_pkg::IDX_STATUS, 32'h80);
        for (w = 0; w < 4; w++) chk(rd(1'b0, a + 2 * w), d[w]);
        rdc(fcs_pkg::IDX_PARAM, d[3]);
        rdc(fcs_pkg::IDX_FAULT, 2 * dfl + sfl);
        bus(1'b1, fcs_pkg::IDX_CONFIG, 32'h0);
        ign = 0;
        for (k = 0; k < 5; k++) begin
            bus(1'b1, fcs_pkg::IDX_FAULT, 32'h3);
            {dfl, sfl} = 0;
            i_read_once_allowed <= k != 2;
            i_arr_ecc_double <= k == 4;
            i_arr_ecc_single <= k == 3;
            cmd(16'h0400, k == 0 ? 16'h8 : 16'h7, k != 1);
            if (k > 2) busy = 1;
            if (k > 2) cpu(1, 0, 0);
            rdc(fcs_pkg::IDX_FAULT, 2 * dfl + sfl);
            finish_cmd();
            rdc(fcs_pkg::IDX_STATUS, k < 3 ? 32'ha0 : (k == 4 ? 32'h83 : 32'h82));
            bus(1'b1, fcs_pkg::IDX_STATUS, 32'h20);
            for (w = 0; w < 4 && k == 3; w++) begin
                bus(1'b1, fcs_pkg::IDX_PARAM_INDEX, w + 2);
                rdc(fcs_pkg::IDX_PARAM, rd(1'b1, 8 * 7 + 2 * w));
            end
            for (w = 0; w < 4 && k == 3; w++) setp(3'(w + 2), 16'h5a5a);
            for (w = 0; w < 4 && k == 3; w++) begin
                bus(1'b1, fcs_pkg::IDX_PARAM_INDEX, w + 2);
                rdc(fcs_pkg::IDX_PARAM, 16'h5a5a);
            end
        end
        complete_run();
    end
endmodule
`default_nettype wire
